// ---- common/uxp_pkg.sv ----
// Package of constants for the universal I/O expansion port bus logic
package uxp_pkg;
    // Board address window and layout
    localparam logic [11:0] UXP_BASE_ADDR     = 12'h040;
    localparam logic [11:0] UXP_LAST_ADDR     = 12'h05F;
    localparam logic [6:0]  UXP_ADDR_PREFIX   = 7'h02;   // Upper seven bits of address
    localparam int          UXP_ADDR_W        = 12;
    // Latch field positions
    localparam int          UXP_CODE_MSB      = 3;
    localparam int          UXP_CODE_LSB      = 1;
    localparam int          UXP_LEVEL_BIT     = 0;
    // Latch codes
    localparam logic [2:0]  UXP_CODE_UNUSED   = 3'h6;
    localparam logic [2:0]  UXP_CODE_READ     = 3'h7;
    localparam logic [3:0]  UXP_SEL_EVEN      = 4'hE;
    localparam logic [3:0]  UXP_SEL_ODD       = 4'hF;
    // Reset values
    localparam logic [3:0]  UXP_LATCH_RST     = 4'h0;
    localparam logic [5:0]  UXP_OUTS_RST      = 6'h3F;   // All loads off
    localparam logic        UXP_SEL_ODD_RST   = 1'b0;
    // Presence answer: bit 0 low when present, other bits high
    localparam logic [3:0]  UXP_PRESENT_DATA  = 4'hE;
    localparam logic [3:0]  UXP_IDLE_DATA     = 4'h0;
    localparam int          UXP_NUM_OUTS      = 6;
    localparam int          UXP_NUM_INS       = 16;
endpackage : uxp_pkg

// ---- hw/uxp_port.sv ----
// Bus-side logic of the universal I/O expansion board
`timescale 1ns/1ps
// Operation
// [R01] Codes 000-101 select heavy outputs 0-5
// [R02] 0xE selects even, 0xF odd inputs
// [R03] First read returns selected half, channels 0-7
// [R04] Second read returns selected half, channels 8-15
// [R05] Each read returns four bits on D3-D0
// [R06] Presence read drives data bit 0 low
// [R07] Bus reset cycle returns board to initial
// [R08] Respond only to addresses 0x040-0x05F
// [R09] Input bit is one above threshold
// [R10] D0 gives output level; code 110 ignored
module uxp_port (
    input  wire logic                          CLK,                      // 200 MHz clock
    input  wire logic                          RST_N,                    // Sync reset, low
    input  wire logic [uxp_pkg::UXP_ADDR_W-1:0] BUS_ADDR,               // Board address
    input  wire logic [3:0]                    PAL_CODE,                 // Decode configuration
    input  wire logic                          ADDR_JUMPER,              // Address low bit jumper
    input  wire logic                          BUS_WRITE_CYCLE,          // Write strobe
    input  wire logic                          PRESENCE_READ_CYCLE,      // Presence read strobe
    input  wire logic                          LOW_INPUTS_READ_CYCLE,    // Channels 0-7 read
    input  wire logic                          HIGH_INPUTS_READ_CYCLE,   // Channels 8-15 read
    input  wire logic                          GLOBAL_BOARD_RESET_CYCLE, // Bus-wide reset
    input  wire logic [3:0]                    BUS_DATA_IN,              // Write data
    input  wire logic [uxp_pkg::UXP_NUM_INS-1:0] COMPARATOR_IN,         // Comparator outputs
    output logic      [3:0]                    BUS_DATA_OUT,             // Read data
    output logic                               BUS_DATA_OE,              // Data drive enable
    output logic                               HEAVY_OUT_0_N,            // Load 0, low is on
    output logic                               HEAVY_OUT_1_N,            // Load 1, low is on
    output logic                               HEAVY_OUT_2_N,            // Load 2, low is on
    output logic                               HEAVY_OUT_3_N,            // Load 3, low is on
    output logic                               HEAVY_OUT_4_N,            // Load 4, low is on
    output logic                               HEAVY_OUT_5_N,            // Load 5, low is on
    output logic      [3:0]                    CHANNEL_SELECT_LATCH,     // Last latch value
    output logic                               SELECT_ODD                // Odd half selected
);
    import uxp_pkg::*;

    // Address layout seen by this board (12 bits):
    //   bits 11:5 fixed prefix, bits 4:1 decode configuration, bit 0 jumper
    // Latch write layout: D3..D1 code, D0 level or half select
    //   code 000-101  set heavy output 0-5 to the level in D0
    //   code 110      ignored, only the latch keeps it
    //   code 111      read setup, D0 low for even, high for odd channels
    // Read answers, one cycle after the strobe:
    //   presence   D0 low, other bits high
    //   low read   selected half of channels 0-7, lowest channel in D0
    //   high read  selected half of channels 8-15, lowest channel in D0

    // Kind of a latch write
    typedef enum logic [1:0] {
        UXP_KIND_OUT,    // Code selects one heavy output
        UXP_KIND_UNUSED, // Code without a function
        UXP_KIND_SETUP   // Read setup
    } uxp_code_kind_type;

    // Address and cycle decode
    logic                    board_hit;      // Address matches this board
    logic                    addr_in_window; // Address inside the board window
    logic                    board_sel;      // Both address checks pass
    logic                    soft_reset;     // Pin reset or bus reset cycle
    logic                    wr_hit;         // Addressed write cycle
    logic                    rd_presence;    // Addressed presence read
    logic                    rd_low;         // Addressed read of channels 0-7
    logic                    rd_high;        // Addressed read of channels 8-15

    // Fields of the write data
    logic [2:0]              wr_code;        // Latch code field
    uxp_code_kind_type       wr_kind;        // Kind of the write code
    logic                    wr_level;       // Level for the coded output
    logic                    wr_setup;       // Write is a read setup
    logic [UXP_NUM_OUTS-1:0] wr_out_sel;     // One-hot output select

    // Stored state
    logic [UXP_NUM_OUTS-1:0] heavy_out_n;    // Output levels, low is on
    logic                    sel_odd;        // Odd half selected

    // Input groups, selected halves and the next read answer
    logic [7:0]              half_low;       // Channels 0-7
    logic [7:0]              half_high;      // Channels 8-15
    logic [3:0]              nib_low;        // Selected half of channels 0-7
    logic [3:0]              nib_high;       // Selected half of channels 8-15
    logic [3:0]              next_data;      // Read answer for the next cycle
    logic                    next_oe;        // Drive enable for the next cycle

    // Code field of a latch write
    function automatic logic [2:0] uxp_code_of(input logic [3:0] wdata);
        return wdata[UXP_CODE_MSB:UXP_CODE_LSB];
    endfunction

    // True when a latch write carries the given code
    function automatic logic uxp_code_is(input logic [3:0] wdata, input logic [2:0] code);
        return uxp_code_of(wdata) == code;
    endfunction

    // Sort a latch code into its kind; the default branch covers the output codes
    function automatic uxp_code_kind_type uxp_kind_of(input logic [2:0] code);
        uxp_code_kind_type kind;
        case (code)
            UXP_CODE_UNUSED: begin
                kind = UXP_KIND_UNUSED;
            end
            UXP_CODE_READ: begin
                kind = UXP_KIND_SETUP;
            end
            default: begin
                kind = UXP_KIND_OUT;
            end
        endcase
        return kind;
    endfunction

    // Gather one half (even or odd) of an eight-channel group
    function automatic logic [3:0] uxp_pick_half(input logic [7:0] grp, input logic odd);
        logic [3:0] res;
        res = '0;
        for (int i = 0; i < 4; i++) begin
            res[i] = grp[2*i + (odd ? 1 : 0)];
        end
        return res;
    endfunction

    // Address match: fixed prefix, decode configuration bits, jumper bit
    assign board_hit = (BUS_ADDR == {UXP_ADDR_PREFIX, PAL_CODE, ADDR_JUMPER}); // [R08]
    // Window check as a second guard; a wrong prefix cannot leak into other boards
    assign addr_in_window = (BUS_ADDR >= UXP_BASE_ADDR) && (BUS_ADDR <= UXP_LAST_ADDR); // [R08]
    assign board_sel = board_hit && addr_in_window;

    // Reset by pin or by bus reset cycle; the bus reset ignores the address
    assign soft_reset = !RST_N || GLOBAL_BOARD_RESET_CYCLE; // [R07]

    // Addressed cycles; priority presence, low, high keeps two strobes from mixing answers
    assign wr_hit      = BUS_WRITE_CYCLE && board_sel;
    assign rd_presence = PRESENCE_READ_CYCLE && board_sel;
    assign rd_low      = LOW_INPUTS_READ_CYCLE && board_sel && !PRESENCE_READ_CYCLE;
    assign rd_high     = HIGH_INPUTS_READ_CYCLE && board_sel
                         && !PRESENCE_READ_CYCLE && !LOW_INPUTS_READ_CYCLE;

    // Fields of the write data
    assign wr_code  = uxp_code_of(BUS_DATA_IN);
    assign wr_kind  = uxp_kind_of(wr_code);
    assign wr_level = BUS_DATA_IN[UXP_LEVEL_BIT]; // [R10]
    assign wr_setup = (wr_kind == UXP_KIND_SETUP); // [R02]

    // One-hot output select; codes 110 and 111 select no output at all
    for (genvar g = 0; g < UXP_NUM_OUTS; g++) begin : g_sel
        assign wr_out_sel[g] = wr_hit && (wr_kind == UXP_KIND_OUT) // [R10]
                               && uxp_code_is(BUS_DATA_IN, 3'(g)); // [R01]
    end

    // Comparator level is the channel value, no inversion and no filtering
    // Limitation: comparator outputs must already be synchronous to CLK
    assign half_low  = COMPARATOR_IN[7:0];  // [R09]
    assign half_high = COMPARATOR_IN[15:8]; // [R09]
    assign nib_low   = uxp_pick_half(half_low, sel_odd);  // [R03] [R05]
    assign nib_high  = uxp_pick_half(half_high, sel_odd); // [R04] [R05]

    // Latch holds the last write addressed to this board, unused code included
    always_ff @(posedge CLK) begin
        if (soft_reset) begin
            CHANNEL_SELECT_LATCH <= UXP_LATCH_RST; // [R07]
        end else if (wr_hit) begin
            CHANNEL_SELECT_LATCH <= BUS_DATA_IN;
        end
    end

    // Read selection kept until another read setup, so many reads may follow one setup
    always_ff @(posedge CLK) begin
        if (soft_reset) begin
            sel_odd <= UXP_SEL_ODD_RST; // [R07]
        end else if (wr_hit && wr_setup) begin
            sel_odd <= (BUS_DATA_IN == UXP_SEL_ODD); // [R02]
        end
    end

    // Selection flag copied out of its flop
    assign SELECT_ODD = sel_odd;

    // One flop per load; only the selected output changes, the others keep their level
    for (genvar g = 0; g < UXP_NUM_OUTS; g++) begin : g_outs
        always_ff @(posedge CLK) begin
            if (soft_reset) begin
                heavy_out_n[g] <= UXP_OUTS_RST[g]; // [R07]
            end else if (wr_out_sel[g]) begin // [R01]
                heavy_out_n[g] <= wr_level; // [R10]
            end
        end
    end

    // Flops drive the load pins directly
    assign HEAVY_OUT_0_N = heavy_out_n[0];
    assign HEAVY_OUT_1_N = heavy_out_n[1];
    assign HEAVY_OUT_2_N = heavy_out_n[2];
    assign HEAVY_OUT_3_N = heavy_out_n[3];
    assign HEAVY_OUT_4_N = heavy_out_n[4];
    assign HEAVY_OUT_5_N = heavy_out_n[5];

    // Next read answer; idle bus shows zero with the drive enable off
    // Registering the answer costs one cycle but keeps the data pins glitch-free
    always_comb begin
        next_data = UXP_IDLE_DATA;
        next_oe   = 1'b0;
        if (rd_presence) begin
            next_data = UXP_PRESENT_DATA; // [R06]
            next_oe   = 1'b1;
        end else if (rd_low) begin
            next_data = nib_low; // [R03] [R05]
            next_oe   = 1'b1;
        end else if (rd_high) begin
            next_data = nib_high; // [R04] [R05]
            next_oe   = 1'b1;
        end
    end

    // Read answer registered one cycle after the strobe; drive only while addressed
    always_ff @(posedge CLK) begin
        if (soft_reset) begin
            BUS_DATA_OUT <= UXP_IDLE_DATA; // [R07]
            BUS_DATA_OE  <= 1'b0;
        end else begin
            BUS_DATA_OUT <= next_data;
            BUS_DATA_OE  <= next_oe;
        end
    end
endmodule // uxp_port

// ---- sim/uxp_port_props.sv ----
// Checker of the expansion port bus rules
`timescale 1ns/1ps
module uxp_port_props (
    input wire logic CLK, RST_N, ADDR_JUMPER, BUS_WRITE_CYCLE, PRESENCE_READ_CYCLE,
    input wire logic LOW_INPUTS_READ_CYCLE, HIGH_INPUTS_READ_CYCLE, GLOBAL_BOARD_RESET_CYCLE,
    input wire logic [11:0] BUS_ADDR,
    input wire logic [3:0] PAL_CODE, BUS_DATA_IN, BUS_DATA_OUT, CHANNEL_SELECT_LATCH,
    input wire logic [15:0] COMPARATOR_IN,
    input wire logic BUS_DATA_OE, SELECT_ODD, HEAVY_OUT_0_N, HEAVY_OUT_1_N, HEAVY_OUT_2_N,
    input wire logic HEAVY_OUT_3_N, HEAVY_OUT_4_N, HEAVY_OUT_5_N
);
    logic       hit;
    logic [5:0] hv;
    logic [3:0] lo, hi;
    // Bus reset outranks any addressed cycle
    assign hit = BUS_ADDR == {7'h02, PAL_CODE, ADDR_JUMPER} && !GLOBAL_BOARD_RESET_CYCLE;
    assign hv = {HEAVY_OUT_5_N, HEAVY_OUT_4_N, HEAVY_OUT_3_N, HEAVY_OUT_2_N, HEAVY_OUT_1_N,
                 HEAVY_OUT_0_N};
    // Expected nibbles for the selected half
    always_comb begin
        lo = 4'h0;
        hi = 4'h0;
        for (int j = 0; j < 4; j++) begin
            lo[j] = COMPARATOR_IN[2 * j + 32'(SELECT_ODD)];
            hi[j] = COMPARATOR_IN[8 + 2 * j + 32'(SELECT_ODD)];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence rd_hit;
        (PRESENCE_READ_CYCLE || LOW_INPUTS_READ_CYCLE || HIGH_INPUTS_READ_CYCLE) && hit;
    endsequence
    read_enable_a: assert property (rd_hit |=> BUS_DATA_OE) else $error("no drive");
    miss_quiet_a: assert property (!((PRESENCE_READ_CYCLE || LOW_INPUTS_READ_CYCLE ||
        HIGH_INPUTS_READ_CYCLE) && hit) |=> !BUS_DATA_OE) else $error("stray drive");
    presence_data_a: assert property (PRESENCE_READ_CYCLE && hit |=> BUS_DATA_OUT == 4'hE)
        else $error("bad presence");
    low_read_a: assert property (LOW_INPUTS_READ_CYCLE && !PRESENCE_READ_CYCLE && hit
        |=> BUS_DATA_OUT == $past(lo)) else $error("bad low read");
    high_read_a: assert property (HIGH_INPUTS_READ_CYCLE && !LOW_INPUTS_READ_CYCLE &&
        !PRESENCE_READ_CYCLE && hit |=> BUS_DATA_OUT == $past(hi)) else $error("bad high read");
    heavy_write_a: assert property (BUS_WRITE_CYCLE && hit && BUS_DATA_IN[3:1] < 3'h6
        |=> hv[$past(BUS_DATA_IN[3:1])] == $past(BUS_DATA_IN[0])) else $error("bad output");
    unused_code_a: assert property (BUS_WRITE_CYCLE && hit && BUS_DATA_IN[3:1] >= 3'h6
        |=> $stable(hv)) else $error("output moved");
    odd_select_a: assert property (BUS_WRITE_CYCLE && hit && BUS_DATA_IN[3:1] == 3'h7
        |=> SELECT_ODD == $past(BUS_DATA_IN[0])) else $error("bad select");
    bus_reset_a: assert property (GLOBAL_BOARD_RESET_CYCLE |=> hv == 6'h3F && !SELECT_ODD)
        else $error("reset missed");
    latch_store_a: assert property (BUS_WRITE_CYCLE && hit
        |=> CHANNEL_SELECT_LATCH == $past(BUS_DATA_IN)) else $error("latch not stored");
endmodule // uxp_port_props
bind uxp_port uxp_port_props P (
    .CLK(CLK), .RST_N(RST_N), .ADDR_JUMPER(ADDR_JUMPER), .BUS_WRITE_CYCLE(BUS_WRITE_CYCLE),
    .PRESENCE_READ_CYCLE(PRESENCE_READ_CYCLE), .LOW_INPUTS_READ_CYCLE(LOW_INPUTS_READ_CYCLE),
    .HIGH_INPUTS_READ_CYCLE(HIGH_INPUTS_READ_CYCLE),
    .GLOBAL_BOARD_RESET_CYCLE(GLOBAL_BOARD_RESET_CYCLE), .BUS_ADDR(BUS_ADDR),
    .PAL_CODE(PAL_CODE), .BUS_DATA_IN(BUS_DATA_IN), .BUS_DATA_OUT(BUS_DATA_OUT),
    .CHANNEL_SELECT_LATCH(CHANNEL_SELECT_LATCH), .COMPARATOR_IN(COMPARATOR_IN),
    .BUS_DATA_OE(BUS_DATA_OE), .SELECT_ODD(SELECT_ODD), .HEAVY_OUT_0_N(HEAVY_OUT_0_N),
    .HEAVY_OUT_1_N(HEAVY_OUT_1_N), .HEAVY_OUT_2_N(HEAVY_OUT_2_N), .HEAVY_OUT_3_N(HEAVY_OUT_3_N),
    .HEAVY_OUT_4_N(HEAVY_OUT_4_N), .HEAVY_OUT_5_N(HEAVY_OUT_5_N)
);

// ---- sim/uxp_master.sv ----
// Master controller model that drives expansion bus cycles
`timescale 1ns/1ps
module uxp_master (
    input  wire logic   clk,    // Bus clock
    output logic [11:0] addr,   // Bus address
    output logic [4:0]  strobe, // Reset, high, low, presence, write
    output logic [3:0]  data    // Write data
);
    // Idle bus at time zero
    initial begin
        addr = 12'h000;
        strobe = 5'h00;
        data = 4'h0;
    end
    // One cycle per transfer; released lines flip so stale values never match
    task cyc(input int k, input logic [11:0] a, input logic [3:0] d);
        @(posedge clk);
        strobe <= 5'h01 << k;
        addr <= a;
        data <= d;
        @(posedge clk);
        strobe <= 5'h00;
        addr <= ~a;
        data <= ~d;
    endtask
endmodule // uxp_master

// ---- sim/tb.sv ----
// Self-checking bench for the expansion port bus logic
`timescale 1ns/1ps
module tb;
    logic clk = 0, rst_n = 0, oe, odd;
    logic [11:0] addr;
    logic [4:0] st;
    logic [3:0] din, dout, latch;
    logic [5:0] hv;
    logic [15:0] cmp = 16'h1E6B;
    int n_mismatch = 0, tests_run = 0;
    localparam logic [11:0] ME = 12'h04B;
    always #2.5 clk = ~clk;
    uxp_master M (.clk(clk), .addr(addr), .strobe(st), .data(din));
    uxp_port DUT (.CLK(clk), .RST_N(rst_n), .BUS_ADDR(addr), .PAL_CODE(4'h5), .ADDR_JUMPER(1'b1),
        .BUS_WRITE_CYCLE(st[0]), .PRESENCE_READ_CYCLE(st[1]), .LOW_INPUTS_READ_CYCLE(st[2]),
        .HIGH_INPUTS_READ_CYCLE(st[3]), .GLOBAL_BOARD_RESET_CYCLE(st[4]), .BUS_DATA_IN(din),
        .COMPARATOR_IN(cmp), .BUS_DATA_OUT(dout), .BUS_DATA_OE(oe), .HEAVY_OUT_0_N(hv[0]),
        .HEAVY_OUT_1_N(hv[1]), .HEAVY_OUT_2_N(hv[2]), .HEAVY_OUT_3_N(hv[3]),
        .HEAVY_OUT_4_N(hv[4]), .HEAVY_OUT_5_N(hv[5]), .CHANNEL_SELECT_LATCH(latch),
        .SELECT_ODD(odd));
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Read data stands for one cycle only, so look just after the taking edge
    task rd(input int k, input logic [11:0] a, input logic [3:0] e, input logic eo);
        M.cyc(k, a, 4'h0);
        #1 chk("read", {eo, 3'h0, e}, {oe, 3'h0, dout});
    endtask
    task tally_and_finish;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("reset outs", 8'h3F, {1'b0, odd, hv});
        chk("reset latch", 8'h00, {4'h0, latch});
        rd(1, ME, 4'hE, 1'b1);
        rd(1, 12'h04A, 4'h0, 1'b0);
        rd(1, 12'h06B, 4'h0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            M.cyc(0, ME, {i[2:0], 1'b0});
            #1 chk("outs", 8'h3F & ~((8'h2 << i) - 8'h1), {2'h0, hv});
        end
        M.cyc(0, ME, 4'hD);
        #1 chk("unused outs", 8'h00, {2'h0, hv});
        chk("unused latch", 8'h0D, {4'h0, latch});
        M.cyc(0, ME, 4'h3);
        #1 chk("outs", 8'h02, {2'h0, hv});
        M.cyc(0, ME, 4'hE);
        rd(2, ME, 4'h9, 1'b1);
        rd(3, ME, 4'h6, 1'b1);
        M.cyc(0, ME, 4'hF);
        #1 chk("select", 8'h1F, {3'h0, odd, latch});
        rd(2, ME, 4'h7, 1'b1);
        rd(3, ME, 4'h3, 1'b1);
        M.cyc(4, 12'h000, 4'h0);
        #1 chk("bus reset", 8'h3F, {1'b0, odd, hv});
        chk("bus reset latch", 8'h00, {4'h0, latch});
        M.cyc(0, 12'h04A, 4'h0);
        #1 chk("miss write", 8'h3F, {2'h0, hv});
        chk("miss latch", 8'h00, {4'h0, latch});
        tally_and_finish;
    end
    // Watchdog well past the few dozen cycles the tests need
    initial begin
        repeat (500) @(posedge clk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule // tb
